// ==== hdl/dsc_defines.svh ====
// constants for the drive setpoint conditioning block
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// input arrangement codes
`define DSC_ARR_PRESET4_JOG   2'h0
`define DSC_ARR_PRESET8       2'h1
`define DSC_ARR_POT_PRESET    2'h2

// manual setpoint select codes: 0..7 presets
`define DSC_MSEL_AUX          4'h8
`define DSC_MSEL_POT          4'h9

// reset values
`define DSC_POT_RST           16'sh0000
`define DSC_ACC_RST           48'h0000_0000_0000
`define DSC_OVL_RST           32'h0000_0000

// slope limits in 0.1 s units
`define DSC_RATE_MIN          16'h0001
`define DSC_RATE_MAX          16'h7530

// overload limits in percent and seconds
`define DSC_THR_MIN           8'h32
`define DSC_THR_MAX           8'h69
`define DSC_UPPER_MIN         8'h32
`define DSC_UPPER_MAX         8'h96
`define DSC_TIME_MIN          8'h05
`define DSC_TIME_MAX          8'h3C

// band width and slip level divisors of the limit frequency
`define DSC_SKIP_DIV          12
`define DSC_SLIP_DIV          24
`define DSC_FULL_LOAD         100
`define DSC_OVERSPEED_PCT     105

// timing: slope unit 0.1 s, overload tick 1 ms, clock 125 MHz
`define DSC_CLK_HZ            125000000
`define DSC_SLOPE_UNIT_MS     100
`define DSC_TICK_MS           1
`define DSC_CYC_PER_SLOPE     (`DSC_CLK_HZ / 1000 * `DSC_SLOPE_UNIT_MS)
`define DSC_CYC_PER_TICK      (`DSC_CLK_HZ / 1000 * `DSC_TICK_MS)
`define DSC_MS_PER_S          1000

`endif

// ==== hdl/dsc_overload.sv ====
// current-times-time overload trip timer
`include "dsc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dsc_overload
    import dsc_pkg::*;
#(
    parameter int CYC_PER_TICK = `DSC_CYC_PER_TICK
) (
    input  wire logic     mclk,
    input  wire logic     rstn,
    input  wire logic     ce,
    input  wire dsc_pct_t current_pct,
    input  wire dsc_pct_t threshold,
    input  wire dsc_pct_t upper_limit,
    input  wire dsc_pct_t overload_time,
    input  wire logic     trip_clear,
    output logic          trip
);
    logic [31:0] tick_q;
    logic [31:0] tick_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic        trip_q;
    logic        trip_d;
    dsc_pct_t    thr_c;
    dsc_pct_t    upr_c;
    dsc_pct_t    tim_c;
    logic [31:0] budget;
    logic        tick;

    function automatic dsc_pct_t clamp_pct(input dsc_pct_t v,
                                           input dsc_pct_t lo,
                                           input dsc_pct_t hi);
        clamp_pct = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp_pct

    always_comb begin
        thr_c  = clamp_pct(threshold, `DSC_THR_MIN, `DSC_THR_MAX);
        upr_c  = clamp_pct(upper_limit, `DSC_UPPER_MIN, `DSC_UPPER_MAX);
        tim_c  = clamp_pct(overload_time, `DSC_TIME_MIN, `DSC_TIME_MAX);
        // trip when sum of (i - thr) dt reaches (upper - thr) * time
        budget = (upr_c > thr_c) ?
                 32'((upr_c - thr_c) * tim_c * `DSC_MS_PER_S) : 32'h0;
        tick   = (tick_q == 32'(CYC_PER_TICK - 1));
        tick_d = tick ? 32'h0 : tick_q + 32'h1;
        acc_d  = acc_q;
        trip_d = trip_q;
        if (current_pct <= thr_c) begin
            acc_d = `DSC_OVL_RST;
        end else if (tick) begin
            acc_d = acc_q + 32'(current_pct - thr_c);
        end
        if (trip_clear) begin
            trip_d = 1'b0;
        end
        if (current_pct > thr_c && acc_q >= budget) begin
            trip_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            tick_q <= `DSC_OVL_RST;
            acc_q  <= `DSC_OVL_RST;
            trip_q <= 1'b0;
        end else if (ce) begin
            tick_q <= tick_d;
            acc_q  <= acc_d;
            trip_q <= trip_d;
        end
    end

    assign trip = trip_q;
endmodule : dsc_overload
`default_nettype wire

// ==== hdl/dsc_pkg.sv ====
// types for the drive setpoint conditioning block
package dsc_pkg;
    typedef logic signed [15:0] dsc_freq_t;
    typedef logic        [7:0]  dsc_pct_t;
    typedef enum logic [1:0] {
        POT_IDLE,
        POT_RAISE,
        POT_LOWER,
        POT_LOAD
    } dsc_pot_state_t;
endpackage : dsc_pkg

// ==== hdl/dsc_top.sv ====
// drive setpoint conditioning: pot setpoint, presets, skip, slip, overload
//
// Functional notes
// - pot works only in pot arrangement
// - input one raises, input two lowers
// - jog input loads pot preset value
// - pot setpoint never part of save
// - raise ramps toward clamped upper target
// - lower ramps toward clamped lower target
// - slopes: limit traverse time, 0.1-3000 s
// - pot frozen while s-ramp selected
// - two preset banks, all eight local
// - four-preset arrangement: inputs pick bank one
// - eight-preset arrangement: third input picks bank
// - four skip bands, each enabled separately
// - demand moved out of each enabled band in turn, before slip
// - band centre clamped zero to limit
// - band width clamped to limit/12
// - keypad aux setpoint used when selected
// - trip after inverse-current overload delay
// - threshold clamped 50 to 105 percent
// - upper limit clamped 50 to 150 percent
// - overload time clamped 5 to 60 s
// - slip adds level scaled by load
// - slip output capped at 105% max speed
`include "dsc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module dsc_top
    import dsc_pkg::*;
#(
    parameter int CYC_PER_SLOPE = `DSC_CYC_PER_SLOPE,
    parameter int CYC_PER_TICK  = `DSC_CYC_PER_TICK
) (
    input  wire logic            mclk,
    input  wire logic            rstn,
    input  wire logic            ce,
    input  wire logic            sel_in1_pin,
    input  wire logic            sel_in2_pin,
    input  wire logic            jog_in3_pin,
    input  wire logic [1:0]      input_arrangement_select,
    input  wire logic [3:0]      manual_select,
    input  wire logic            s_ramp_selected,
    input  wire dsc_freq_t       limit_freq,
    input  wire dsc_freq_t       max_speed,
    input  wire dsc_freq_t       pot_upper_target,
    input  wire dsc_freq_t       pot_lower_target,
    input  wire dsc_freq_t       pot_load_value,
    input  wire logic [15:0]     pot_increase_time,
    input  wire logic [15:0]     pot_decrease_time,
    input  wire dsc_freq_t [7:0] preset_speed,
    input  wire dsc_freq_t       operator_keypad_setpoint,
    input  wire logic [3:0]      skip_band_enables,
    input  wire dsc_freq_t [3:0] skip_band_centre,
    input  wire dsc_freq_t [3:0] skip_band_width,
    input  wire dsc_freq_t       demand_freq,
    input  wire dsc_freq_t       slip_comp_level,
    input  wire dsc_pct_t        load_pct,
    input  wire dsc_pct_t        current_pct,
    input  wire dsc_pct_t        overload_threshold,
    input  wire dsc_pct_t        overload_upper_limit,
    input  wire dsc_pct_t        overload_time,
    input  wire logic            overload_trip_clear,
    output dsc_freq_t            motorised_pot_setpoint,
    output dsc_freq_t            manual_setpoint,
    output dsc_freq_t            remote_preset,
    output logic                 pot_active,
    output dsc_freq_t            output_freq,
    output logic                 overload_trip
);
    // pin synchronisers
    logic [2:0]     pin_s1_q;
    logic [2:0]     pin_s2_q;
    logic           raise;
    logic           lower;
    logic           load;
    // pot state
    dsc_pot_state_t st_q;
    dsc_pot_state_t st_d;
    dsc_freq_t      pot_q;
    dsc_freq_t      pot_d;
    logic [47:0]    acc_q;
    logic [47:0]    acc_d;
    logic [47:0]    slope_thr;
    logic [15:0]    rate;
    dsc_freq_t      upper_c;
    dsc_freq_t      lower_c;
    dsc_freq_t      target;
    dsc_freq_t      neg_limit;
    logic           pot_mode;
    // setpoint selection and output path
    dsc_freq_t      man_q;
    dsc_freq_t      man_d;
    dsc_freq_t      rem_q;
    dsc_freq_t      rem_d;
    dsc_freq_t      out_q;
    dsc_freq_t      out_d;
    dsc_freq_t      skip_chain [0:4];
    dsc_freq_t      slip_c;
    logic [31:0]    slip_add;
    logic signed [17:0] with_slip;
    logic signed [17:0] cap;

    function automatic dsc_freq_t clamp_f(input dsc_freq_t v,
                                          input dsc_freq_t lo,
                                          input dsc_freq_t hi);
        clamp_f = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp_f

    function automatic logic [15:0] clamp_rate(input logic [15:0] v);
        clamp_rate = (v < `DSC_RATE_MIN) ? `DSC_RATE_MIN :
                     ((v > `DSC_RATE_MAX) ? `DSC_RATE_MAX : v);
    endfunction : clamp_rate

    // moves a magnitude inside (centre +- width/2) out to the nearer edge
    function automatic dsc_freq_t skip_band(input dsc_freq_t f,
                                            input dsc_freq_t centre,
                                            input dsc_freq_t width);
        dsc_freq_t mag;
        dsc_freq_t half;
        dsc_freq_t lo;
        dsc_freq_t hi;
        mag  = (f < 0) ? -f : f;
        half = width >>> 1;
        lo   = centre - half;
        hi   = centre + half;
        if (mag > lo && mag < hi) begin
            mag = (mag < centre) ? lo : hi;
        end
        skip_band = (f < 0) ? -mag : mag;
    endfunction : skip_band

    // two-flop synchronisers on the terminal inputs
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
        end else if (ce) begin
            pin_s1_q <= {jog_in3_pin, sel_in2_pin, sel_in1_pin};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign raise = pin_s2_q[0];
    assign lower = pin_s2_q[1];
    assign load  = pin_s2_q[2];

    // pot setpoint: command decode and slope generator
    always_comb begin
        neg_limit = -limit_freq;
        pot_mode  = (input_arrangement_select == `DSC_ARR_POT_PRESET) &&
                    !s_ramp_selected;
        upper_c   = clamp_f(pot_upper_target, neg_limit, limit_freq);
        lower_c   = clamp_f(pot_lower_target, neg_limit, limit_freq);
        st_d      = POT_IDLE;
        if (pot_mode) begin
            if (load) begin
                st_d = POT_LOAD;
            end else if (raise && !lower) begin
                st_d = POT_RAISE;
            end else if (lower && !raise) begin
                st_d = POT_LOWER;
            end else begin
                st_d = POT_IDLE;
            end
        end
        case (st_q)
            POT_RAISE: target = upper_c;
            POT_LOWER: target = lower_c;
            default:   target = pot_q;
        endcase
        rate = (st_q == POT_LOWER) ? clamp_rate(pot_decrease_time) :
                                     clamp_rate(pot_increase_time);
        // one lsb per slope_thr/limit cycles: limit lsbs per rate time
        slope_thr = 48'(rate) * 48'(CYC_PER_SLOPE);
        pot_d = pot_q;
        acc_d = acc_q;
        case (st_q)
            POT_LOAD: begin
                pot_d = clamp_f(pot_load_value, neg_limit, limit_freq);
                acc_d = `DSC_ACC_RST;
            end
            POT_RAISE, POT_LOWER: begin
                if (pot_q == target) begin
                    acc_d = `DSC_ACC_RST;
                end else if (acc_q + 48'(limit_freq) >= slope_thr) begin
                    acc_d = acc_q + 48'(limit_freq) - slope_thr;
                    pot_d = (pot_q < target) ? pot_q + 16'sh0001 :
                                               pot_q - 16'sh0001;
                end else begin
                    acc_d = acc_q + 48'(limit_freq);
                end
            end
            POT_IDLE: begin
                acc_d = `DSC_ACC_RST;
            end
            default: begin
                acc_d = `DSC_ACC_RST;
            end
        endcase
    end

    // volatile only: no save path carries this register
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_q  <= POT_IDLE;
            pot_q <= `DSC_POT_RST;
            acc_q <= `DSC_ACC_RST;
        end else if (ce) begin
            st_q  <= st_d;
            pot_q <= pot_d;
            acc_q <= acc_d;
        end
    end

    // skip band chain over the four bands
    assign skip_chain[0] = demand_freq;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_skip
            dsc_freq_t centre_c;
            dsc_freq_t width_c;
            assign centre_c = clamp_f(skip_band_centre[gi], 16'sh0000,
                                      limit_freq);
            assign width_c  = clamp_f(skip_band_width[gi], 16'sh0000,
                                      16'(limit_freq / `DSC_SKIP_DIV));
            assign skip_chain[gi+1] = skip_band_enables[gi] ?
                skip_band(skip_chain[gi], centre_c, width_c) :
                skip_chain[gi];
        end
    endgenerate

    // setpoint selection, slip compensation and speed cap
    always_comb begin
        case (manual_select)
            `DSC_MSEL_AUX: man_d = clamp_f(operator_keypad_setpoint,
                                           -limit_freq, limit_freq);
            `DSC_MSEL_POT: man_d = pot_q;
            default: man_d = preset_speed[manual_select[2:0]];
        endcase
        case (input_arrangement_select)
            `DSC_ARR_PRESET4_JOG:
                rem_d = preset_speed[{1'b0, pin_s2_q[1:0]}];
            `DSC_ARR_PRESET8:
                rem_d = preset_speed[pin_s2_q[2:0]];
            `DSC_ARR_POT_PRESET:
                rem_d = pot_q;
            default:
                rem_d = rem_q;
        endcase
        slip_c   = clamp_f(slip_comp_level, 16'sh0000,
                           16'(limit_freq / `DSC_SLIP_DIV));
        slip_add = 32'(32'(slip_c) * load_pct) / `DSC_FULL_LOAD;
        if (skip_chain[4] < 0) begin
            with_slip = 18'(skip_chain[4]) - 18'(slip_add[15:0]);
        end else begin
            with_slip = 18'(skip_chain[4]) + 18'(slip_add[15:0]);
        end
        cap = 18'((32'(max_speed) * `DSC_OVERSPEED_PCT) / 100);
        if (with_slip > cap) begin
            out_d = 16'(cap);
        end else if (with_slip < -cap) begin
            out_d = 16'(-cap);
        end else begin
            out_d = 16'(with_slip);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            man_q <= `DSC_POT_RST;
            rem_q <= `DSC_POT_RST;
            out_q <= `DSC_POT_RST;
        end else if (ce) begin
            man_q <= man_d;
            rem_q <= rem_d;
            out_q <= out_d;
        end
    end

    dsc_overload #(
        .CYC_PER_TICK (CYC_PER_TICK)
    ) u_overload (
        .mclk          (mclk),
        .rstn          (rstn),
        .ce            (ce),
        .current_pct   (current_pct),
        .threshold     (overload_threshold),
        .upper_limit   (overload_upper_limit),
        .overload_time (overload_time),
        .trip_clear    (overload_trip_clear),
        .trip          (overload_trip)
    );

    assign motorised_pot_setpoint = pot_q;
    assign manual_setpoint        = man_q;
    assign remote_preset          = rem_q;
    assign output_freq            = out_q;
    assign pot_active             = (input_arrangement_select ==
                                     `DSC_ARR_POT_PRESET) && !s_ramp_selected;
endmodule : dsc_top
`default_nettype wire

// ==== verif/dsc_terminal_model.sv ====
// terminal and current-measurement model facing the block
`timescale 1ns/10ps
`default_nettype none
module dsc_terminal_model
    import dsc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [2:0] term_req,
    input  wire dsc_pct_t   cur_req,
    output logic            sel_in1_pin,
    output logic            sel_in2_pin,
    output logic            jog_in3_pin,
    output dsc_pct_t        current_pct
);
    // terminal levels change only just after a clock edge
    always @(posedge mclk) begin
        sel_in1_pin <= term_req[0];
        sel_in2_pin <= term_req[1];
        jog_in3_pin <= term_req[2];
        current_pct <= cur_req;
    end
endmodule : dsc_terminal_model
`default_nettype wire

// ==== verif/dsc_top_monitor.sv ====
// port-level assertions for the setpoint conditioning block
`timescale 1ns/10ps
`default_nettype none
module dsc_top_monitor
    import dsc_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rstn,
    input wire logic [1:0]      input_arrangement_select,
    input wire logic [3:0]      manual_select,
    input wire logic            s_ramp_selected,
    input wire dsc_freq_t       limit_freq,
    input wire dsc_freq_t       max_speed,
    input wire dsc_freq_t       pot_load_value,
    input wire dsc_freq_t [7:0] preset_speed,
    input wire dsc_freq_t       operator_keypad_setpoint,
    input wire logic [3:0]      skip_band_enables,
    input wire dsc_freq_t [3:0] skip_band_centre,
    input wire dsc_freq_t [3:0] skip_band_width,
    input wire dsc_freq_t       slip_comp_level,
    input wire dsc_pct_t        current_pct,
    input wire dsc_pct_t        overload_threshold,
    input wire logic            overload_trip_clear,
    input wire dsc_freq_t       motorised_pot_setpoint,
    input wire dsc_freq_t       manual_setpoint,
    input wire logic            pot_active,
    input wire dsc_freq_t       output_freq,
    input wire logic            overload_trip
);
    int cap;
    int lo0;
    int hi0;
    int omag;
    // band zero edges and output magnitude, both signs folded
    always_comb begin
        cap  = int'(max_speed) * 105 / 100;
        lo0  = int'(skip_band_centre[0]) - int'(skip_band_width[0]) / 2;
        hi0  = int'(skip_band_centre[0]) + int'(skip_band_width[0]) / 2;
        omag = (output_freq < 0) ? -int'(output_freq) : int'(output_freq);
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    pot_enable_a: assert property (
        pot_active == (input_arrangement_select == 2'h2 && !s_ramp_selected))
        else $error("pot enable wrong");
    pot_frozen_a: assert property (
        !pot_active && $past(!pot_active) |=> $stable(motorised_pot_setpoint))
        else $error("pot moved while disabled");
    pot_bounds_a: assert property (
        motorised_pot_setpoint <= limit_freq
        && motorised_pot_setpoint >= -limit_freq)
        else $error("pot outside limit");
    pot_step_a: assert property (
        $changed(motorised_pot_setpoint) |->
        (motorised_pot_setpoint - $past(motorised_pot_setpoint))
        inside {16'sh0001, 16'shFFFF}
        || motorised_pot_setpoint == pot_load_value)
        else $error("pot jumped");
    preset_pick_a: assert property (
        manual_select < 4'h8 |=>
        manual_setpoint == $past(preset_speed[manual_select]))
        else $error("manual preset wrong");
    keypad_pick_a: assert property (
        manual_select == 4'h8 |=>
        manual_setpoint == $past(operator_keypad_setpoint))
        else $error("keypad setpoint wrong");
    trip_sticky_a: assert property (
        overload_trip && !overload_trip_clear |=> overload_trip)
        else $error("trip dropped");
    trip_quiet_a: assert property (
        (!overload_trip || overload_trip_clear)
        && current_pct <= overload_threshold |=> !overload_trip)
        else $error("trip without overload");
    skip_avoid_a: assert property (
        skip_band_enables == 4'h1 && slip_comp_level == 16'sh0000 |=>
        !(omag > $past(lo0) && omag < $past(hi0)))
        else $error("output inside skip band");
    speed_cap_a: assert property (
        omag <= cap)
        else $error("output above speed cap");
    skip_seen_c: cover property (skip_band_enables == 4'h1);
endmodule : dsc_top_monitor
bind dsc_top dsc_top_monitor u_mon (.mclk, .rstn,
    .input_arrangement_select, .manual_select, .s_ramp_selected,
    .limit_freq, .max_speed, .pot_load_value, .preset_speed,
    .operator_keypad_setpoint, .skip_band_enables, .skip_band_centre,
    .skip_band_width, .slip_comp_level, .current_pct, .overload_threshold,
    .overload_trip_clear, .motorised_pot_setpoint, .manual_setpoint,
    .pot_active, .output_freq, .overload_trip);
`default_nettype wire

// ==== verif/dsc_top_tb.sv ====
// self-checking bench for the setpoint conditioning block
`timescale 1ns/10ps
`default_nettype none
module dsc_top_tb
    import dsc_pkg::*;
;
    logic            mclk = 1'b0;
    logic            rstn = 1'b0;
    logic            ce = 1'b1;
    logic [2:0]      term_req = 3'h0;
    dsc_pct_t        cur_req = 8'h00;
    wire logic       sel_in1_pin, sel_in2_pin, jog_in3_pin;
    wire dsc_pct_t   current_pct;
    logic [1:0]      input_arrangement_select = 2'h3;
    logic [3:0]      manual_select = 4'h0;
    logic            s_ramp_selected = 1'b0;
    dsc_freq_t       limit_freq = 16'sh0064;
    dsc_freq_t       max_speed = 16'sh0064;
    dsc_freq_t       pot_upper_target = 16'sh0028;
    dsc_freq_t       pot_lower_target = 16'shFFE2;
    dsc_freq_t       pot_load_value = 16'sh000A;
    logic [15:0]     pot_increase_time = 16'h0014;
    logic [15:0]     pot_decrease_time = 16'h000A;
    dsc_freq_t [7:0] preset_speed;
    dsc_freq_t       operator_keypad_setpoint = 16'shFFEC;
    logic [3:0]      skip_band_enables = 4'h0;
    dsc_freq_t [3:0] skip_band_centre = '0;
    dsc_freq_t [3:0] skip_band_width = '0;
    dsc_freq_t       demand_freq = 16'sh0000;
    dsc_freq_t       slip_comp_level = 16'sh0000;
    dsc_pct_t        load_pct = 8'h00;
    dsc_pct_t        overload_threshold = 8'h69;
    dsc_pct_t        overload_upper_limit = 8'h96;
    dsc_pct_t        overload_time = 8'h3C;
    logic            overload_trip_clear = 1'b0;
    dsc_freq_t       motorised_pot_setpoint, manual_setpoint, remote_preset;
    dsc_freq_t       output_freq;
    logic            pot_active, overload_trip;
    int              n_fail = 0;
    int              check_count = 0;
    // enable, centre, width, slip level, load, demand, expected output
    logic [15:0] tv [10][7] = '{
        '{16'h0, 16'h0032, 16'h0008, 16'h0, 16'h0, 16'h0031, 16'h0031},
        '{16'h1, 16'h0032, 16'h0008, 16'h0, 16'h0, 16'h0031, 16'h002E},
        '{16'h2, 16'h0032, 16'h0008, 16'h0, 16'h0, 16'h0034, 16'h0036},
        '{16'h4, 16'h0032, 16'h0014, 16'h0, 16'h0, 16'h002D, 16'h002D},
        '{16'h8, 16'h00C8, 16'h0008, 16'h0, 16'h0, 16'h0062, 16'h0060},
        '{16'h0, 16'h0, 16'h0, 16'h0004, 16'h0032, 16'h001E, 16'h0020},
        '{16'h0, 16'h0, 16'h0, 16'h0004, 16'h0032, 16'hFFE2, 16'hFFE0},
        '{16'h0, 16'h0, 16'h0, 16'h000A, 16'h0064, 16'h0010, 16'h0014},
        '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0070, 16'h0069},
        '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hFF90, 16'hFF97}};
    // threshold, upper limit, time, current; trip cycles at tick of 10
    logic [7:0] ov [2][4] = '{'{8'h6E, 8'h6E, 8'h02, 8'h7D},
                              '{8'h69, 8'hC8, 8'h05, 8'hFF}};
    int exp_cyc [2] = '{12500, 15000};

    always #4 mclk = ~mclk;

    dsc_terminal_model u_term (.mclk, .term_req, .cur_req, .sel_in1_pin,
        .sel_in2_pin, .jog_in3_pin, .current_pct);
    dsc_top #(.CYC_PER_SLOPE(10), .CYC_PER_TICK(10)) DUT (.mclk, .rstn, .ce,
        .sel_in1_pin, .sel_in2_pin, .jog_in3_pin, .input_arrangement_select,
        .manual_select, .s_ramp_selected, .limit_freq, .max_speed,
        .pot_upper_target, .pot_lower_target, .pot_load_value,
        .pot_increase_time, .pot_decrease_time, .preset_speed,
        .operator_keypad_setpoint, .skip_band_enables, .skip_band_centre,
        .skip_band_width, .demand_freq, .slip_comp_level, .load_pct,
        .current_pct, .overload_threshold, .overload_upper_limit,
        .overload_time, .overload_trip_clear, .motorised_pot_setpoint,
        .manual_setpoint, .remote_preset, .pot_active, .output_freq,
        .overload_trip);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // wait n edges, then move to the settled half of the cycle
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic set_term(input logic [2:0] t);
        @(posedge mclk);
        term_req <= t;
    endtask : set_term

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (60000) @(posedge mclk);
        n_fail++;
        end_sim();
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            preset_speed[i] = dsc_freq_t'(i * 10 + 3);
        end
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        settle(1);
        check(motorised_pot_setpoint, 16'h0000);
        check({15'h0000, overload_trip}, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            @(posedge mclk);
            manual_select <= 4'(i);
            settle(2);
            check(manual_setpoint, (i < 8) ? 16'(i * 10 + 3) : 16'hFFEC);
        end
        @(posedge mclk);
        input_arrangement_select <= 2'h2;
        set_term(3'b101);
        settle(20);
        check(motorised_pot_setpoint, 16'h000A);
        check({15'h0000, pot_active}, 16'h0001);
        set_term(3'b001);
        settle(30);
        check({15'h0000, motorised_pot_setpoint > 16'sh0011
            && motorised_pot_setpoint < 16'sh001B}, 16'h0001);
        settle(60);
        check(motorised_pot_setpoint, 16'h0028);
        set_term(3'b010);
        settle(30);
        check({15'h0000, motorised_pot_setpoint > 16'sh0007
            && motorised_pot_setpoint < 16'sh0015}, 16'h0001);
        // clock enable low freezes the slope mid-ramp
        @(posedge mclk);
        ce <= 1'b0;
        settle(10);
        check(motorised_pot_setpoint, 16'h000D);
        @(posedge mclk);
        ce <= 1'b1;
        settle(80);
        check(motorised_pot_setpoint, 16'hFFE2);
        set_term(3'b011);
        manual_select <= 4'h9;
        settle(30);
        check(motorised_pot_setpoint, 16'hFFE2);
        check(manual_setpoint, 16'hFFE2);
        set_term(3'b001);
        s_ramp_selected <= 1'b1;
        settle(30);
        check(motorised_pot_setpoint, 16'hFFE2);
        check({15'h0000, pot_active}, 16'h0000);
        @(posedge mclk);
        s_ramp_selected <= 1'b0;
        input_arrangement_select <= 2'h0;
        settle(30);
        check(motorised_pot_setpoint, 16'hFFE2);
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk);
            input_arrangement_select <= (i < 4) ? 2'h0 : 2'h1;
            set_term(3'(i % 8));
            settle(6);
            check(remote_preset, 16'((i % 8) * 10 + 3));
        end
        for (int k = 0; k < 10; k++) begin
            @(posedge mclk);
            skip_band_enables <= tv[k][0][3:0];
            for (int b = 0; b < 4; b++) begin
                skip_band_centre[b] <= tv[k][1];
                skip_band_width[b]  <= tv[k][2];
            end
            slip_comp_level <= tv[k][3];
            load_pct        <= tv[k][4][7:0];
            demand_freq     <= tv[k][5];
            settle(2);
            check(output_freq, tv[k][6]);
        end
        for (int r = 0; r < 2; r++) begin
            @(posedge mclk);
            overload_threshold   <= ov[r][0];
            overload_upper_limit <= ov[r][1];
            overload_time        <= ov[r][2];
            cur_req              <= ov[r][3];
            settle(exp_cyc[r] - 500);
            check({15'h0000, overload_trip}, 16'h0000);
            settle(1000);
            check({15'h0000, overload_trip}, 16'h0001);
            @(posedge mclk);
            cur_req <= 8'h00;
            settle(20);
            check({15'h0000, overload_trip}, 16'h0001);
            @(posedge mclk);
            overload_trip_clear <= 1'b1;
            @(posedge mclk);
            overload_trip_clear <= 1'b0;
            settle(2);
            check({15'h0000, overload_trip}, 16'h0000);
        end
        end_sim();
    end
endmodule : dsc_top_tb
`default_nettype wire
